// ==== mic_pkg.sv ====
package mic_pkg;
    localparam logic [7:0] REG_ADDR       = 8'h0b;
    localparam int         BIT_GLOBAL_EN  = 0;
    localparam int         BIT_EXT_EN     = 1;
    localparam int         BIT_TMR_EN     = 2;
    localparam int         BIT_ADC_EN     = 3;
    localparam int         BIT_EXT_PEND   = 4;
    localparam int         BIT_TMR_PEND   = 5;
    localparam int         BIT_ADC_PEND   = 6;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [7:0] REG_WMASK      = 8'h7f;
    localparam logic [7:0] VEC_EXT        = 8'h04;
    localparam logic [7:0] VEC_TMR        = 8'h08;
    localparam logic [7:0] VEC_ADC        = 8'h0c;
    localparam logic [7:0] VEC_NONE       = 8'h00;

    typedef struct packed {
        logic       valid;
        logic [1:0] src;
        logic [7:0] vector;
    } mic_ack_s;

    typedef enum logic [1:0] {
        MIC_SRC_EXT,
        MIC_SRC_TMR,
        MIC_SRC_ADC,
        MIC_SRC_NONE
    } mic_src_e;

    function automatic logic [7:0] mic_vector(input logic [1:0] src);
        case (src)
            2'h0:    mic_vector = VEC_EXT;
            2'h1:    mic_vector = VEC_TMR;
            2'h2:    mic_vector = VEC_ADC;
            default: mic_vector = VEC_NONE;
        endcase
    endfunction
endpackage

// ==== mic_sync_fall.sv ====
`timescale 1ns/1ns
module mic_sync_fall
    import mic_pkg::*;
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic pin_in,
    output logic      fall_pulse
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            last_r <= 1'b1;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign fall_pulse = last_r & ~sync_r;
endmodule

// ==== mic_prio.sv ====
`timescale 1ns/1ns
module mic_prio
    import mic_pkg::*;
(
    input  wire logic [2:0] ready,
    output mic_ack_s        pick
);
    always_comb begin
        pick = '0;
        if (ready[0]) begin
            pick.valid = 1'b1;
            pick.src   = 2'h0;
        end else if (ready[1]) begin
            pick.valid = 1'b1;
            pick.src   = 2'h1;
        end else if (ready[2]) begin
            pick.valid = 1'b1;
            pick.src   = 2'h2;
        end
        pick.vector = pick.valid ? mic_vector(pick.src) : VEC_NONE;
    end
endmodule

// ==== mic_ctrl.sv ====
`timescale 1ns/1ns
// Behaviour
// - Bit 0 global enable gates acknowledgment
// - Bit 1 enables external request
// - Bit 2 enables timer overflow request
// - Bit 3 enables A/D complete request
// - Bit 4 external pending flag
// - Bit 5 timer pending flag
// - Bit 6 A/D pending flag
// - Hold acks until re-enabled, stack permitting
// - Return-with-enable sets global enable; return not
// - Requests sampled, acted on at phase-two pulse
// - Priority external, timer, A/D; fixed vectors
// - Cleared enables mask pending requests
// - Flags stay until serviced or cleared
// - Register mapped at data address 0Bh
// - Ack pushes, vectors, clears flag, clears global
// - Full stack records but withholds ack
// - External flag set on falling pin edge
module mic_ctrl
    import mic_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       ext_irq_n,
    input  wire logic       timer_ovf,
    input  wire logic       adc_done,
    input  wire logic       phase_two_pulse,
    input  wire logic       stack_full,
    input  wire logic       return_with_enable,
    input  wire logic       ack_taken,
    input  wire logic [7:0] mem_addr,
    input  wire logic       mem_wr,
    input  wire logic       mem_rd,
    input  wire logic [7:0] mem_wdata,
    output logic      [7:0] mem_rdata,
    output logic            irq_req,
    output logic      [7:0] irq_vector,
    output logic            push_pc,
    output logic      [7:0] flags_out
);
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [7:0] rdata_r;
    logic       req_r;
    logic [7:0] vec_r;
    logic       push_r;
    logic       ext_fall;
    logic [2:0] pending;
    logic [2:0] enabled;
    logic [2:0] ready;
    mic_ack_s   pick;
    logic       sel;
    logic       wr_hit;
    logic       rd_hit;
    logic       ack_fire;

    mic_sync_fall u_sync (
        .clk        (clk),
        .srst       (srst),
        .pin_in     (ext_irq_n),
        .fall_pulse (ext_fall)
    );

    // Flags already held when the sample point arrives
    assign pending = flags_r[BIT_ADC_PEND:BIT_EXT_PEND];
    // Per-source enables, all masked by the global enable
    assign enabled = flags_r[BIT_ADC_EN:BIT_EXT_EN]
                   & {3{flags_r[BIT_GLOBAL_EN]}};
    assign ready   = pending & enabled;

    mic_prio u_prio (
        .ready (ready),
        .pick  (pick)
    );

    assign sel    = (mem_addr == REG_ADDR);
    assign wr_hit = mem_wr & sel;
    assign rd_hit = mem_rd & sel;

    // Acknowledge only on a sample point, with room on the stack
    assign ack_fire = phase_two_pulse & pick.valid
                    & ~stack_full & ~req_r;

    always_comb begin
        flags_nxt = flags_r;
        if (wr_hit) begin
            flags_nxt = mem_wdata & REG_WMASK;
        end
        if (ack_fire) begin
            flags_nxt[BIT_GLOBAL_EN] = 1'b0;
            flags_nxt[BIT_EXT_PEND + pick.src] = 1'b0;
        end
        if (return_with_enable) begin
            flags_nxt[BIT_GLOBAL_EN] = 1'b1;
        end
        // Hardware set wins over software clear
        if (ext_fall) begin
            flags_nxt[BIT_EXT_PEND] = 1'b1;
        end
        if (timer_ovf) begin
            flags_nxt[BIT_TMR_PEND] = 1'b1;
        end
        if (adc_done) begin
            flags_nxt[BIT_ADC_PEND] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            flags_r <= REG_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= 8'h00;
        end else if (rd_hit) begin
            rdata_r <= flags_r;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // Request held until the sequencer takes it
    always_ff @(posedge clk) begin
        if (srst) begin
            req_r  <= 1'b0;
            vec_r  <= VEC_NONE;
            push_r <= 1'b0;
        end else begin
            push_r <= ack_fire;
            if (ack_fire) begin
                req_r <= 1'b1;
                vec_r <= pick.vector;
            end else if (ack_taken) begin
                req_r <= 1'b0;
            end
        end
    end

    assign mem_rdata  = rdata_r;
    assign irq_req    = req_r;
    assign irq_vector = vec_r;
    assign push_pc    = push_r;
    assign flags_out  = flags_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // Acknowledge walk: sample point, answer, then push ends
    sequence seq_ack_edge;
        ack_fire;
    endsequence

    sequence seq_ack_answer;
        irq_req && push_pc && (irq_vector != VEC_NONE);
    endsequence

    sequence seq_push_ends;
        !push_pc;
    endsequence

    AST_ACK_WALK: assert property (
        seq_ack_edge |=> seq_ack_answer ##1 seq_push_ends)
        else $error("acknowledge walk broken");

    AST_NO_ACK_FULL: assert property (
        stack_full |-> !ack_fire)
        else $error("ack while stack full");

    AST_NO_ACK_GLOBAL: assert property (
        !flags_r[BIT_GLOBAL_EN] |=> !push_pc)
        else $error("ack with global enable low");

    AST_ACK_CLEARS_EN: assert property (
        ack_fire && !return_with_enable |=> !flags_r[BIT_GLOBAL_EN])
        else $error("global enable not cleared on ack");

    AST_RETURN_WITH_ENABLE_SETS: assert property (
        return_with_enable |=> flags_r[BIT_GLOBAL_EN])
        else $error("return with enable failed");

    AST_EXT_PRIO: assert property (
        ack_fire && ready[0] |=> irq_vector == VEC_EXT)
        else $error("external not first");

    AST_TMR_PRIO: assert property (
        ack_fire && !ready[0] && ready[1] |=> irq_vector == VEC_TMR)
        else $error("timer vector wrong");

    AST_ADC_PRIO: assert property (
        ack_fire && ready == 3'h4 |=> irq_vector == VEC_ADC)
        else $error("A/D vector wrong");

    AST_EXT_FALL: assert property (
        ext_fall |=> flags_r[BIT_EXT_PEND])
        else $error("external flag not set");

    AST_TMR_SET: assert property (
        timer_ovf |=> flags_r[BIT_TMR_PEND])
        else $error("timer flag not set");

    AST_ADC_SET: assert property (
        adc_done |=> flags_r[BIT_ADC_PEND])
        else $error("A/D flag not set");

    AST_FLAG_STAYS: assert property (
        flags_r[BIT_TMR_PEND] && !ack_fire && !wr_hit
        |=> flags_r[BIT_TMR_PEND])
        else $error("timer flag dropped");

    AST_EXT_STAYS: assert property (
        flags_r[BIT_EXT_PEND] && !ack_fire && !wr_hit
        |=> flags_r[BIT_EXT_PEND])
        else $error("external flag dropped");

    AST_ADC_STAYS: assert property (
        flags_r[BIT_ADC_PEND] && !ack_fire && !wr_hit
        |=> flags_r[BIT_ADC_PEND])
        else $error("A/D flag dropped");

    AST_EXT_ACK_CLEARS: assert property (
        ack_fire && pick.src == 2'h0 && !ext_fall
        |=> !flags_r[BIT_EXT_PEND])
        else $error("external flag kept after ack");

    AST_TMR_ACK_CLEARS: assert property (
        ack_fire && pick.src == 2'h1 && !timer_ovf
        |=> !flags_r[BIT_TMR_PEND])
        else $error("timer flag kept after ack");

    AST_ADC_ACK_CLEARS: assert property (
        ack_fire && pick.src == 2'h2 && !adc_done
        |=> !flags_r[BIT_ADC_PEND])
        else $error("A/D flag kept after ack");

    AST_EXT_NEEDS_FLAG: assert property (
        ack_fire && pick.src == 2'h0 |-> flags_r[BIT_EXT_PEND])
        else $error("external ack without flag");

    AST_EXT_MASKED: assert property (
        !flags_r[BIT_EXT_EN] |-> !(ack_fire && pick.src == 2'h0))
        else $error("external ack while disabled");

    AST_TMR_MASKED: assert property (
        !flags_r[BIT_TMR_EN] |-> !(ack_fire && pick.src == 2'h1))
        else $error("timer ack while disabled");

    AST_ADC_MASKED: assert property (
        !flags_r[BIT_ADC_EN] |-> !(ack_fire && pick.src == 2'h2))
        else $error("A/D ack while disabled");

    AST_GLOBAL_MASKS: assert property (
        !flags_r[BIT_GLOBAL_EN] |-> !ack_fire)
        else $error("ack while globally masked");

    AST_ACK_ONLY_PULSE: assert property (
        !phase_two_pulse |-> !ack_fire)
        else $error("ack between sample points");

    AST_ACK_ON_PULSE: assert property (
        $rose(push_pc) |-> $past(phase_two_pulse))
        else $error("ack off phase-two pulse");

    AST_NO_ACK_BUSY: assert property (
        irq_req |-> !ack_fire)
        else $error("second ack while request held");

    AST_REQ_HOLDS: assert property (
        irq_req && !ack_taken |=> irq_req)
        else $error("request dropped early");

    AST_REQ_DROPS: assert property (
        irq_req && ack_taken |=> !irq_req)
        else $error("request kept after taken");

    AST_VEC_STABLE: assert property (
        irq_req && !push_pc |-> $stable(irq_vector))
        else $error("vector moved while held");

    AST_FULL_NO_PUSH: assert property (
        stack_full |=> !push_pc)
        else $error("push with stack full");

    AST_READ_DATA: assert property (
        rd_hit |=> mem_rdata == $past(flags_r))
        else $error("read data wrong");

    AST_READ_IDLE: assert property (
        !rd_hit |=> mem_rdata == 8'h00)
        else $error("read data not idle");

    AST_WRITE_LANDS: assert property (
        wr_hit && !ack_fire && !return_with_enable && !ext_fall
        && !timer_ovf && !adc_done
        |=> flags_r == ($past(mem_wdata) & REG_WMASK))
        else $error("write did not land");

    AST_BIT7_ZERO: assert property (
        !flags_r[7])
        else $error("bit 7 set");

    AST_BIT7_READ: assert property (
        !mem_rdata[7])
        else $error("bit 7 read as one");
endmodule

// ==== mic_seq_model.sv ====
`timescale 1ns/1ns
module mic_seq_model
    import mic_pkg::*;
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic irq_req,
    output logic      phase_two_pulse,
    output logic      ack_taken
);
    logic [1:0] phase_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end

    // One sample point every four clocks
    always_ff @(posedge clk) begin
        phase_two_pulse <= !srst && phase_r == 2'h3;
    end

    // Enters the routine and never calls from inside it
    always_ff @(posedge clk) begin
        ack_taken <= !srst && irq_req && !ack_taken;
    end
endmodule

// ==== tb_mic_ctrl.sv ====
`timescale 1ns/1ns
module tb_mic_ctrl;
    import mic_pkg::*;
    logic clk = 0, srst = 1, ext_irq_n = 1, timer_ovf = 0, adc_done = 0;
    logic stack_full = 0, return_with_enable = 0, mem_wr = 0, mem_rd = 0;
    logic [7:0]  mem_addr = REG_ADDR, mem_wdata = 8'h00, cur = 8'h00;
    logic [15:0] lfsr = 16'heb7e;
    wire logic       phase_two_pulse, ack_taken, irq_req, push_pc;
    wire logic [7:0] mem_rdata, irq_vector, flags_out;
    int error_cnt = 0, comparisons = 0;

    always #5 clk = ~clk;

    mic_seq_model partner (.clk(clk), .srst(srst), .irq_req(irq_req),
        .phase_two_pulse(phase_two_pulse), .ack_taken(ack_taken));
    mic_ctrl dut (.clk(clk), .srst(srst), .ext_irq_n(ext_irq_n),
        .timer_ovf(timer_ovf), .adc_done(adc_done), .stack_full(stack_full),
        .phase_two_pulse(phase_two_pulse), .ack_taken(ack_taken),
        .return_with_enable(return_with_enable), .mem_addr(mem_addr),
        .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .irq_req(irq_req), .irq_vector(irq_vector),
        .push_pc(push_pc), .flags_out(flags_out));

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // Highest enabled pending source wins; returns vector and new register
    function automatic logic [15:0] ack_model(input logic [7:0] r);
        for (int i = 0; i < 3; i++) begin
            if (r[i+1] && r[i+4]) begin
                return {8'((i + 1) * 4), r & ~(8'h10 << i) & 8'hfe};
            end
        end
        return {VEC_NONE, r};
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] d);
        @(negedge clk);
        mem_wdata = d & 8'h7f;
        mem_wr = 1;
        @(negedge clk);
        mem_wr = 0;
    endtask

    task automatic tick_src(input logic [1:0] k);
        @(negedge clk);
        {adc_done, timer_ovf} = k;
        @(negedge clk);
        {adc_done, timer_ovf} = 2'b00;
    endtask

    task automatic rwe;
        @(negedge clk);
        return_with_enable = 1;
        @(negedge clk);
        return_with_enable = 0;
        cur[0] = 1'b1;
    endtask

    task automatic idle(input logic [7:0] exp);
        repeat (12) @(negedge clk);
        chk({7'h0, irq_req}, 8'h00);
        chk(flags_out, exp);
    endtask

    task automatic serve;
        logic [15:0] e;
        e = ack_model(cur);
        for (int n = 0; n < 40 && irq_req !== 1'b1; n++) @(negedge clk);
        chk({6'h0, irq_req, push_pc}, 8'h03);
        chk(irq_vector, e[15:8]);
        cur = e[7:0];
        @(negedge clk);
        chk(flags_out, cur);
        chk({7'h0, push_pc}, 8'h00);
        for (int n = 0; n < 10 && irq_req !== 1'b0; n++) @(negedge clk);
    endtask

    initial begin
        #100000;
        error_cnt++;
        complete_run;
    end

    initial begin
        repeat (16) @(negedge clk);
        srst = 0;
        @(negedge clk);
        chk(flags_out, REG_RESET);
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            wr(lfsr[7:0] & 8'h7e);
            mem_rd = 1;
            @(negedge clk);
            chk(mem_rdata, lfsr[7:0] & 8'h7e);
            mem_rd = 0;
        end
        mem_addr = 8'h0a;
        mem_rd = 1;
        @(negedge clk);
        chk(mem_rdata, 8'h00);
        mem_rd = 0;
        mem_addr = REG_ADDR;
        wr(8'h00);
        tick_src(2'b11);
        ext_irq_n = 0;
        repeat (6) @(negedge clk);
        ext_irq_n = 1;
        idle(8'h70);
        wr(8'h7f);
        cur = 8'h7f;
        serve;
        rwe;
        serve;
        rwe;
        serve;
        rwe;
        stack_full = 1;
        tick_src(2'b01);
        cur[5] = 1'b1;
        idle(cur);
        stack_full = 0;
        serve;
        wr(8'h0b);
        cur = 8'h0b;
        tick_src(2'b01);
        cur = 8'h2b;
        idle(cur);
        ext_irq_n = 0;
        cur = 8'h3b;
        serve;
        ext_irq_n = 1;
        wr(8'h00);
        idle(8'h00);
        complete_run;
    end
endmodule
